// ==== logic/lpi_pkg.sv ====
// Purpose: Shared constants and types for the memory power-up sequencer and the memory-side model.
// Assumes: mclk at 100 MHz on both ends; the link clock is made by the controller.
// Notes: Times are kept in their own units; cycle counts are derived from them.
package lpi_pkg;
  localparam int MCLK_PERIOD_NS = 10;
  // Half period of the link clock in mclk cycles.
  localparam int CK_HALF_CYC = 1;
  localparam int CK_PERIOD_CYC = 2 * CK_HALF_CYC;
  localparam int T_CKB_MIN_NS = 18;

  function automatic int cyc_min(input int ns);
    int c;
    c = (ns + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  function automatic int max2(input int a, input int b);
    return (a > b) ? a : b;
  endfunction

  localparam int T_INIT1_US = 200;
  localparam int T_INIT2_NS = 10;
  localparam int T_INIT3_MS = 2;
  localparam int T_INIT4_TCK = 5;
  localparam int T_INIT5_US = 2;
  localparam int T_ZQCAL_US = 1;
  localparam int T_ZQLAT_NS = 30;
  localparam int T_ZQLAT_TCK = 8;
  localparam int T_PW_RESET_NS = 100;

  localparam int INIT1_CYC = cyc_min(T_INIT1_US * 1000);
  localparam int INIT2_CYC = cyc_min(T_INIT2_NS);
  localparam int INIT3_CYC = cyc_min(T_INIT3_MS * 1000000);
  localparam int INIT4_CYC = T_INIT4_TCK * CK_PERIOD_CYC;
  localparam int INIT5_CYC = cyc_min(T_INIT5_US * 1000);
  localparam int ZQCAL_CYC = cyc_min(T_ZQCAL_US * 1000);
  localparam int ZQLAT_CYC = max2(cyc_min(T_ZQLAT_NS), T_ZQLAT_TCK * CK_PERIOD_CYC);
  localparam int PW_RESET_CYC = max2(cyc_min(T_PW_RESET_NS), INIT2_CYC);
  localparam int CMD_GAP_CYC = 4 * CK_PERIOD_CYC;
  localparam int SETTLE_CYC = 16;
  localparam int CNT_W = 24;

  typedef enum logic [2:0] {
    CMD_NOP = 3'h0, CMD_MRW = 3'h1, CMD_MRR = 3'h2, CMD_ZQS = 3'h3,
    CMD_ZQL = 3'h4, CMD_FWR = 3'h5, CMD_FRD = 3'h6, CMD_RDC = 3'h7
  } lpi_cmd_t;

  localparam int ST_W = 11;
  typedef enum logic [ST_W-1:0] {
    ST_OFF = 11'h001, ST_RST = 11'h002, ST_CKE_WAIT = 11'h004, ST_IDLE5 = 11'h008,
    ST_MRW = 11'h010, ST_ZQ_START = 11'h020, ST_ZQ_LATCH = 11'h040, ST_CBT = 11'h080,
    ST_WL = 11'h100, ST_DQT = 11'h200, ST_READY = 11'h400
  } lpi_state_t;

  localparam logic [5:0] MR_ADDR_1 = 6'h01;
  localparam logic [5:0] MR_ADDR_2 = 6'h02;
  localparam logic [5:0] MR_ADDR_3 = 6'h03;
  localparam logic [5:0] MR_ADDR_11 = 6'h0B;
  localparam logic [5:0] MR_ADDR_12 = 6'h0C;
  localparam logic [5:0] MR_ADDR_13 = 6'h0D;
  localparam logic [5:0] MR_ADDR_14 = 6'h0E;

  localparam logic [7:0] MR1_DEF = 8'h00;
  localparam logic [7:0] MR2_DEF = 8'h00;
  localparam logic [7:0] MR3_DEF = 8'h00;
  localparam logic [7:0] MR11_DEF = 8'h00;
  localparam logic [7:0] MR13_DEF = 8'h00;
  localparam logic [7:0] VREF_DEF_LV = 8'h5D;
  localparam logic [7:0] VREF_DEF_STD = 8'h4D;
  localparam int WL_LEV_BIT = 7;
  localparam int CBT_BIT = 0;
  localparam logic [7:0] WL_LEV_MASK = 8'h80;
  localparam logic [7:0] CBT_MASK = 8'h01;

  localparam logic [7:0] CAL_PATTERN = 8'h5A;
  localparam logic [5:0] CBT_PATTERN = 6'h2A;
  localparam logic [7:0] DQT_PATTERN = 8'hC3;
  localparam logic [7:0] ODT_SETTING_DEF = 8'h33;

  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;
  localparam logic [ADDR_W-1:0] REG_MRW = 4'h8;
  localparam int CTRL_COLD_BIT = 0;
  localparam int CTRL_WARM_BIT = 1;
  localparam int STAT_READY = 0;
  localparam int STAT_CBT_OK = 1;
  localparam int STAT_WL_RES = 2;
  localparam int STAT_DQ_OK = 3;
  localparam int STAT_PEND = 4;
  localparam int STAT_STATE_LSB = 8;
  localparam int MRW_MA_LSB = 8;
endpackage

// ==== logic/lpi_link_if.sv ====
// Purpose: Pins between the sequencer and the memory-side model.
// Assumes: The data bus is driven only by the memory side.
// Notes: A released data bus reads as zero, as if terminated to ground.
interface lpi_link_if;
  logic reset_n;
  logic cke;
  logic cs;
  logic ck;
  logic dqs;
  lpi_pkg::lpi_cmd_t cmd;
  logic [5:0] ma;
  logic [7:0] op;
  logic [7:0] dq_o;
  logic dq_oe_n;
  wire [7:0] dq;

  assign dq = dq_oe_n ? 8'h00 : dq_o;

  modport ctrl (output reset_n, cke, cs, ck, dqs, cmd, ma, op, input dq);
  modport dram (input reset_n, cke, cs, ck, dqs, cmd, ma, op, output dq_o, dq_oe_n);
endinterface

// ==== logic/lpi_dram.sv ====
// Purpose: Memory-side end: mode register defaults, reset and output release, training responses.
// Assumes: All link inputs are asynchronous to mclk and pass two flip-flops first.
// Notes: Has no storage array; training reads use a one-word buffer and a fixed pattern.
module lpi_dram #(
  parameter bit LOW_VOLT = 1'b1
) (
  input wire logic mclk,
  input wire logic srst,
  lpi_link_if.dram link,
  output logic [7:0] mr1,
  output logic [7:0] mr2,
  output logic [7:0] mr3,
  output logic [7:0] mr11,
  output logic [7:0] mr12,
  output logic [7:0] mr13,
  output logic [7:0] mr14,
  output logic in_reset,
  output logic out_hiz,
  output logic zq_applied,
  output logic cmd_seen,
  output lpi_pkg::lpi_cmd_t last_cmd
);
  import lpi_pkg::*;

  localparam int IN_W = 22;
  localparam logic [7:0] VREF_DEF = LOW_VOLT ? VREF_DEF_LV : VREF_DEF_STD;

  logic [IN_W-1:0] in_s1, in_s2;
  logic ck_prev, dqs_prev, zq_run;
  logic [7:0] fifo_word;

  wire reset_n_s = in_s2[21];
  wire cke_s = in_s2[20];
  wire cs_s = in_s2[19];
  wire ck_s = in_s2[18];
  wire dqs_s = in_s2[17];
  wire lpi_cmd_t cmd_s = lpi_cmd_t'(in_s2[16:14]);
  wire [5:0] ma_s = in_s2[13:8];
  wire [7:0] op_s = in_s2[7:0];
  wire ck_rise = ck_s && !ck_prev;
  wire dqs_rise = dqs_s && !dqs_prev;
  wire active = reset_n_s && cke_s;
  wire take = ck_rise && active && cs_s;
  wire is_read = (cmd_s == CMD_MRR) || (cmd_s == CMD_FRD) || (cmd_s == CMD_RDC);
  // Mode register read select; the registers are operands here so a later write is seen at once.
  wire [7:0] mr_read = (ma_s == MR_ADDR_1) ? mr1 :
                       (ma_s == MR_ADDR_2) ? mr2 :
                       (ma_s == MR_ADDR_3) ? mr3 :
                       (ma_s == MR_ADDR_11) ? mr11 :
                       (ma_s == MR_ADDR_12) ? mr12 :
                       (ma_s == MR_ADDR_13) ? mr13 :
                       (ma_s == MR_ADDR_14) ? mr14 : 8'h00;
  wire [7:0] read_word = (cmd_s == CMD_FRD) ? fifo_word : (cmd_s == CMD_RDC) ? CAL_PATTERN : mr_read;

  always_ff @(posedge mclk) begin
    in_s1 <= {link.reset_n, link.cke, link.cs, link.ck, link.dqs, link.cmd, link.ma, link.op};
    in_s2 <= in_s1;
    ck_prev <= ck_s;
    dqs_prev <= dqs_s;
  end

  always_ff @(posedge mclk) begin
    if (srst || !reset_n_s) begin
      mr1 <= MR1_DEF;
      mr2 <= MR2_DEF;
      mr3 <= MR3_DEF;
      mr11 <= MR11_DEF;
      mr12 <= VREF_DEF;
      mr13 <= MR13_DEF;
      mr14 <= VREF_DEF;
      zq_run <= 1'b0;
      zq_applied <= 1'b0;
      fifo_word <= 8'h00;
    end else if (take) begin
      case (cmd_s)
        CMD_MRW: begin
          case (ma_s)
            MR_ADDR_1: mr1 <= op_s;
            MR_ADDR_2: mr2 <= op_s;
            MR_ADDR_3: mr3 <= op_s;
            MR_ADDR_11: mr11 <= op_s;
            MR_ADDR_12: mr12 <= op_s;
            MR_ADDR_13: mr13 <= op_s;
            MR_ADDR_14: mr14 <= op_s;
            default: mr1 <= mr1;
          endcase
        end
        CMD_ZQS: zq_run <= 1'b1;
        CMD_ZQL: begin
          zq_applied <= zq_run;
          zq_run <= 1'b0;
        end
        CMD_FWR: fifo_word <= op_s;
        default: zq_run <= zq_run;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (srst || !active) begin
      link.dq_oe_n <= 1'b1;
      link.dq_o <= 8'h00;
    end else if (mr13[CBT_BIT]) begin
      link.dq_oe_n <= 1'b0;
      link.dq_o <= {2'b00, ma_s};
    end else if (mr2[WL_LEV_BIT] && dqs_rise) begin
      link.dq_oe_n <= 1'b0;
      link.dq_o <= {7'h00, ck_s};
    end else if (take) begin
      link.dq_oe_n <= !is_read;
      link.dq_o <= is_read ? read_word : 8'h00;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      in_reset <= 1'b1;
      out_hiz <= 1'b1;
      cmd_seen <= 1'b0;
      last_cmd <= CMD_NOP;
    end else begin
      in_reset <= !reset_n_s;
      out_hiz <= link.dq_oe_n;
      cmd_seen <= take;
      if (take) begin
        last_cmd <= cmd_s;
      end
    end
  end
endmodule // lpi_dram

// ==== logic/lpi_ctrl.sv ====
// Purpose: Controller end: drives reset, clock enable, clock and commands through power-up and training.
// Assumes: Software starts it by a register write; one channel per instance, all channels started together.
// Notes: The link clock is mclk divided down; commands change on its falling edge.
// Summary of operation
// - Memory defaults latency, recovery, set point zero.
// - Memory defaults inversion and termination off.
// - Low-voltage reference defaults range 1, 011101.
// - Standard command reference defaults 001101.
// - Memory outputs released while reset low.
// - Reset held low 200 us after ramp.
// - Clock enable low 10 ns before release.
// - Clock enable low 2 ms after release.
// - Five stable clocks before clock enable.
// - Chip select low when clock enable rises.
// - Wait 2 us before first register access.
// - Boot clock period no shorter than 18 ns.
// - Calibration start, wait 1 us, latch.
// - Shared resistor calibrations never overlap.
// - Quiet after latch: max 30 ns, 8 clocks.
// - Command training echoes command bus on data.
// - Write leveling follows command training.
// - Data training uses buffer and calibration reads.
// - After training, any command; software writes rest.
// - Warm reset: 100 ns low, then repeat.
// - Power-off holds clock enable low, outputs released.
// - All channels start together, never in turn.
// - Reset may be asserted from any state.
module lpi_ctrl #(
  parameter int INIT1_CYCLES = lpi_pkg::INIT1_CYC,
  parameter int INIT3_CYCLES = lpi_pkg::INIT3_CYC,
  parameter logic [7:0] ODT_SETTING = lpi_pkg::ODT_SETTING_DEF
) (
  input wire logic mclk,
  input wire logic srst,
  lpi_link_if.ctrl link,
  input wire logic [lpi_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic zq_req,
  input wire logic zq_grant,
  output logic ready
);
  import lpi_pkg::*;

  localparam logic [1:0] SUB_LAST = 2'd2;
  localparam int DIV_W = 4;

  lpi_state_t state, next_state;
  logic [1:0] sub;
  logic [CNT_W-1:0] cnt, rst_len, wait_sel;
  logic [DIV_W-1:0] div_cnt;
  logic sent, needs_cmd, gate;
  logic [7:0] dq_s1, dq_s;
  logic gnt_s1, gnt_s;
  logic cbt_ok, wl_result, dq_ok;
  logic u_pend;
  logic [5:0] u_ma, ma_sel;
  logic [7:0] u_op, op_sel;
  lpi_cmd_t cmd_sel;
  logic [31:0] status_word;

  wire ck_en = (div_cnt == DIV_W'(CK_HALF_CYC - 1));
  wire fall = ck_en && link.ck;
  wire wr_ctrl = reg_wr && (reg_addr == REG_CTRL);
  // One write starts every channel instance on the same edge.
  wire cold_req = wr_ctrl && reg_wdata[CTRL_COLD_BIT];
  wire warm_req = wr_ctrl && reg_wdata[CTRL_WARM_BIT];
  wire wr_mrw = reg_wr && (reg_addr == REG_MRW);
  wire in_ready = (state == ST_READY);
  wire idle_state = (state == ST_OFF) || in_ready;
  wire multi = (state == ST_CBT) || (state == ST_WL) || (state == ST_DQT);
  wire last_sub = !multi || (sub == SUB_LAST);
  wire want = needs_cmd && gate;
  wire issue_now = fall && want && !sent;
  wire adv = (sent || !needs_cmd) && (cnt >= wait_sel) && !idle_state;
  wire hold_reset = (state == ST_OFF) || (state == ST_RST);
  wire cke_low = hold_reset || (state == ST_CKE_WAIT);
  wire [31:0] rd_word = (reg_addr == REG_STATUS) ? status_word :
                        (reg_addr == REG_MRW) ? {16'h0000, 2'b00, u_ma, u_op} : 32'h0000_0000;

  always_comb begin
    needs_cmd = 1'b1;
    gate = 1'b1;
    cmd_sel = CMD_NOP;
    ma_sel = 6'h00;
    op_sel = 8'h00;
    wait_sel = CNT_W'(CMD_GAP_CYC);
    next_state = state;
    case (state)
      ST_OFF: begin
        needs_cmd = 1'b0;
      end
      ST_RST: begin
        needs_cmd = 1'b0;
        wait_sel = rst_len;
        next_state = ST_CKE_WAIT;
      end
      ST_CKE_WAIT: begin
        needs_cmd = 1'b0;
        wait_sel = CNT_W'(max2(INIT3_CYCLES, INIT4_CYC));
        next_state = ST_IDLE5;
      end
      ST_IDLE5: begin
        needs_cmd = 1'b0;
        wait_sel = CNT_W'(INIT5_CYC);
        next_state = ST_MRW;
      end
      ST_MRW: begin
        cmd_sel = CMD_MRW;
        ma_sel = MR_ADDR_11;
        op_sel = ODT_SETTING;
        next_state = ST_ZQ_START;
      end
      ST_ZQ_START: begin
        gate = gnt_s;
        cmd_sel = CMD_ZQS;
        wait_sel = CNT_W'(ZQCAL_CYC);
        next_state = ST_ZQ_LATCH;
      end
      ST_ZQ_LATCH: begin
        cmd_sel = CMD_ZQL;
        wait_sel = CNT_W'(ZQLAT_CYC);
        next_state = ST_CBT;
      end
      ST_CBT: begin
        cmd_sel = (sub == 2'd1) ? CMD_NOP : CMD_MRW;
        ma_sel = (sub == 2'd1) ? CBT_PATTERN : MR_ADDR_13;
        op_sel = (sub == 2'd0) ? (MR13_DEF | CBT_MASK) : MR13_DEF;
        wait_sel = (sub == 2'd1) ? CNT_W'(SETTLE_CYC) : CNT_W'(CMD_GAP_CYC);
        next_state = ST_WL;
      end
      ST_WL: begin
        cmd_sel = (sub == 2'd1) ? CMD_NOP : CMD_MRW;
        ma_sel = MR_ADDR_2;
        op_sel = (sub == 2'd0) ? (MR2_DEF | WL_LEV_MASK) : MR2_DEF;
        wait_sel = (sub == 2'd1) ? CNT_W'(SETTLE_CYC) : CNT_W'(CMD_GAP_CYC);
        next_state = ST_DQT;
      end
      ST_DQT: begin
        cmd_sel = (sub == 2'd0) ? CMD_FWR : (sub == 2'd1) ? CMD_FRD : CMD_RDC;
        op_sel = DQT_PATTERN;
        wait_sel = (sub == 2'd1) ? CNT_W'(SETTLE_CYC) : CNT_W'(CMD_GAP_CYC);
        next_state = ST_READY;
      end
      ST_READY: begin
        gate = u_pend;
        cmd_sel = CMD_MRW;
        ma_sel = u_ma;
        op_sel = u_op;
      end
      default: begin
        next_state = ST_OFF;
      end
    endcase
  end

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[STAT_READY] = ready;
    status_word[STAT_CBT_OK] = cbt_ok;
    status_word[STAT_WL_RES] = wl_result;
    status_word[STAT_DQ_OK] = dq_ok;
    status_word[STAT_PEND] = u_pend;
    status_word[STAT_STATE_LSB +: ST_W] = state;
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      state <= ST_OFF;
      sub <= 2'd0;
      cnt <= '0;
      sent <= 1'b0;
      rst_len <= '0;
    end else if (cold_req || warm_req) begin
      state <= ST_RST;
      sub <= 2'd0;
      cnt <= '0;
      sent <= 1'b0;
      rst_len <= cold_req ? CNT_W'(INIT1_CYCLES) : CNT_W'(PW_RESET_CYC);
    end else if (adv) begin
      sub <= last_sub ? 2'd0 : sub + 2'd1;
      state <= last_sub ? next_state : state;
      cnt <= '0;
      sent <= 1'b0;
    end else if (issue_now) begin
      sent <= !in_ready;
      cnt <= '0;
    end else if (cnt < wait_sel) begin
      cnt <= cnt + CNT_W'(1);
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      div_cnt <= '0;
      link.ck <= 1'b0;
    end else begin
      div_cnt <= ck_en ? '0 : div_cnt + DIV_W'(1);
      link.ck <= ck_en ? !link.ck : link.ck;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      link.reset_n <= 1'b0;
      link.cke <= 1'b0;
      link.cs <= 1'b0;
      link.dqs <= 1'b0;
      link.cmd <= CMD_NOP;
      link.ma <= 6'h00;
      link.op <= 8'h00;
      zq_req <= 1'b0;
      ready <= 1'b0;
    end else begin
      link.reset_n <= !hold_reset;
      link.cke <= !cke_low;
      zq_req <= (state == ST_ZQ_START) || (state == ST_ZQ_LATCH);
      ready <= in_ready;
      if (fall) begin
        link.cmd <= issue_now ? cmd_sel : CMD_NOP;
        link.cs <= issue_now && (cmd_sel != CMD_NOP);
        link.dqs <= issue_now && (state == ST_WL) && (sub == 2'd1);
        if (issue_now) begin
          link.ma <= ma_sel;
          link.op <= op_sel;
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    dq_s1 <= link.dq;
    dq_s <= dq_s1;
    gnt_s1 <= zq_grant;
    gnt_s <= gnt_s1;
  end

  always_ff @(posedge mclk) begin
    if (srst || cold_req || warm_req) begin
      cbt_ok <= 1'b0;
      wl_result <= 1'b0;
      dq_ok <= 1'b0;
    end else if (issue_now && (sub == SUB_LAST)) begin
      cbt_ok <= (state == ST_CBT) ? (dq_s[5:0] == CBT_PATTERN) : cbt_ok;
      wl_result <= (state == ST_WL) ? dq_s[0] : wl_result;
      dq_ok <= (state == ST_DQT) ? (dq_s == DQT_PATTERN) : dq_ok;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst || cold_req || warm_req) begin
      u_pend <= 1'b0;
      u_ma <= 6'h00;
      u_op <= 8'h00;
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= reg_rd ? rd_word : 32'h0000_0000;
      if (wr_mrw && in_ready) begin
        u_pend <= 1'b1;
        u_ma <= reg_wdata[MRW_MA_LSB +: 6];
        u_op <= reg_wdata[7:0];
      end else if (issue_now && in_ready) begin
        u_pend <= 1'b0;
      end
    end
  end
endmodule // lpi_ctrl

// ==== verif/lpi_link_checker.sv ====
// Purpose: Timing checks on the link between the sequencer and the memory end.
// Assumes: One mclk domain; srst disables every check.
// Notes: An issue is the first cycle of a chip-select pulse.
module lpi_link_checker #(
  parameter int INIT3_CYCLES = 50
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic reset_n,
  input wire logic cke,
  input wire logic cs,
  input wire logic ck,
  input wire lpi_pkg::lpi_cmd_t cmd,
  input wire logic dq_oe_n
);
  import lpi_pkg::*;
  logic cs_q;
  logic [15:0] since;
  logic [15:0] lo_cnt;
  logic [15:0] hi_cnt;
  logic [15:0] up_cnt;
  lpi_cmd_t prev_cmd;
  wire issue = cs && !cs_q;

  function automatic logic [15:0] sat(input logic [15:0] v);
    return (v == 16'hFFFF) ? v : v + 16'h0001;
  endfunction

  // Counters saturate so that long idle stretches never wrap back below a minimum.
  always_ff @(posedge mclk) begin
    cs_q <= cs && !srst;
    since <= (issue || srst) ? 16'h0001 : sat(since);
    prev_cmd <= srst ? CMD_NOP : (issue ? cmd : prev_cmd);
    lo_cnt <= (reset_n || srst) ? 16'h0000 : sat(lo_cnt);
    hi_cnt <= (!reset_n || cke || srst) ? 16'h0000 : sat(hi_cnt);
    up_cnt <= (cke && !srst) ? sat(up_cnt) : 16'h0000;
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  sequence zq_latch_issue;
    issue && cmd == CMD_ZQL;
  endsequence
  sequence one_slot;
    cs ##1 !cs;
  endsequence

  rst_pulse_min_a: assert property ($rose(reset_n) |-> lo_cnt >= 16'(PW_RESET_CYC))
    else $error("reset pulse too short");
  cke_pre_release_a: assert property ($rose(reset_n) |-> !cke && $past(cke) == 1'b0)
    else $error("clock enable high at reset release");
  cke_post_release_a: assert property ($rose(cke) |-> hi_cnt >= 16'(INIT3_CYCLES))
    else $error("clock enable raised too early");
  clock_stable_a: assert property ($rose(cke) |-> $past(ck, 1) != $past(ck, 2) && $past(ck, 9) != $past(ck, 10))
    else $error("link clock not running before clock enable");
  cs_low_cke_a: assert property ($rose(cke) |-> !cs)
    else $error("chip select high at clock enable rise");
  mode_access_wait_a: assert property (issue && cmd inside {CMD_MRW, CMD_MRR} |-> up_cnt >= 16'(INIT5_CYC))
    else $error("mode access too soon after clock enable");
  cmd_width_a: assert property (issue |=> one_slot)
    else $error("command slot not one link clock");
  zq_cal_wait_a: assert property (zq_latch_issue |-> prev_cmd == CMD_ZQS && since >= 16'(ZQCAL_CYC))
    else $error("calibration latch too early");
  zq_quiet_a: assert property (issue && prev_cmd == CMD_ZQL |-> since >= 16'(ZQLAT_CYC))
    else $error("bus not quiet after latch");
  hiz_reset_a: assert property (!reset_n [*4] |-> dq_oe_n)
    else $error("data driven during reset");
  hiz_cke_low_a: assert property (!cke [*4] |-> dq_oe_n)
    else $error("data driven with clock enable low");
endmodule // lpi_link_checker

// ==== verif/dram_power_up_init_sequence_test.sv ====
// Purpose: Runs both ends through cold start, training, register access and warm reset.
// Assumes: Shortened reset and clock enable waits; a second memory end at standard voltage.
// Notes: The bench drives the second memory end directly, releases its reset and holds its clock enable low.
module dram_power_up_init_sequence_test;
  timeunit 1ns;
  timeprecision 1ns;
  import lpi_pkg::*;
  localparam int INIT1 = 50;
  localparam int INIT3 = 50;
  logic mclk;
  logic srst;
  logic reg_wr;
  logic reg_rd;
  logic zq_grant;
  logic [ADDR_W-1:0] reg_addr;
  logic [31:0] reg_wdata;
  logic [31:0] rd_val;
  wire [31:0] reg_rdata;
  wire zq_req, ready, in_reset, out_hiz, zq_applied, cmd_seen, s_hiz;
  wire [7:0] mr1, mr2, mr3, mr11, mr12, mr13, mr14, s_mr12;
  lpi_cmd_t last_cmd;
  int failures;
  int total_checks;
  int cycles;
  int cmd_count = 0;
  lpi_link_if link();
  lpi_link_if side();

  lpi_ctrl #(.INIT1_CYCLES(INIT1), .INIT3_CYCLES(INIT3)) lpi_ctrl_inst (.mclk(mclk), .srst(srst),
    .link(link.ctrl), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .zq_req(zq_req), .zq_grant(zq_grant), .ready(ready));
  lpi_dram lpi_dram_inst (.mclk(mclk), .srst(srst), .link(link.dram), .mr1(mr1), .mr2(mr2), .mr3(mr3),
    .mr11(mr11), .mr12(mr12), .mr13(mr13), .mr14(mr14), .in_reset(in_reset), .out_hiz(out_hiz),
    .zq_applied(zq_applied), .cmd_seen(cmd_seen), .last_cmd(last_cmd));
  lpi_dram #(.LOW_VOLT(1'b0)) lpi_dram_std_inst (.mclk(mclk), .srst(srst), .link(side.dram), .mr1(), .mr2(),
    .mr3(), .mr11(), .mr12(s_mr12), .mr13(), .mr14(), .in_reset(), .out_hiz(s_hiz), .zq_applied(),
    .cmd_seen(), .last_cmd());
  lpi_link_checker #(.INIT3_CYCLES(INIT3)) lpi_link_checker_inst (.mclk(mclk), .srst(srst),
    .reset_n(link.reset_n), .cke(link.cke), .cs(link.cs), .ck(link.ck), .cmd(link.cmd), .dq_oe_n(link.dq_oe_n));

  task automatic print_verdict();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic reg_write(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [ADDR_W-1:0] a, output logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    // Read data stand for one cycle and are taken at the edge that closes it.
    @(posedge mclk);
    d = reg_rdata;
  endtask

  // Status after training: ready, both training passes, no pending write, state READY.
  task automatic chk_ready_status();
    reg_read(REG_STATUS, rd_val);
    chk("status_ready", rd_val & 32'h0007_FF1B, 32'h0004_000B);
    chk("link_up", 32'({link.reset_n, link.cke}), 32'h3);
  endtask

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Counts the commands that the low-voltage memory end takes.
  always @(posedge mclk) begin
    if (cmd_seen === 1'b1) begin
      cmd_count++;
    end
  end

  // Cuts a hang short; the whole sequence needs fewer than 1500 cycles.
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 10000) begin
      failures++;
      print_verdict();
    end
  end

  initial begin
    int n;
    srst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    zq_grant = 1'b0;
    side.reset_n = 1'b0;
    side.cke = 1'b0;
    side.cs = 1'b0;
    side.ck = 1'b0;
    side.dqs = 1'b0;
    side.cmd = CMD_NOP;
    side.ma = '0;
    side.op = '0;
    failures = 0;
    total_checks = 0;
    cycles = 0;
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    reg_write(4'hC, 32'hFFFF_FFFF);
    reg_write(REG_MRW, {18'h0, MR_ADDR_1, 8'h70});
    reg_read(REG_STATUS, rd_val);
    chk("status_off", rd_val, 32'h0000_0100);
    reg_read(4'hC, rd_val);
    chk("unmapped", rd_val, 32'h0);
    chk("link_off", 32'({link.reset_n, link.cke}), 32'h0);
    chk("mr_lat", 32'(mr1 | mr2 | mr13), 32'h0);
    chk("mr_dbi_odt", 32'(mr3 | mr11), 32'h0);
    chk("mr12_lv", 32'(mr12), 32'({2'b01, 6'b011101}));
    chk("mr14_lv", 32'(mr14), 32'({2'b01, 6'b011101}));
    chk("mr12_std", 32'(s_mr12), 32'({2'b01, 6'b001101}));
    chk("std_hiz", 32'(s_hiz), 32'h1);
    side.reset_n <= 1'b1;
    reg_write(REG_CTRL, 32'h1);
    wait (zq_req === 1'b1);
    repeat (200) @(posedge mclk);
    chk("zq_held", 32'(zq_applied), 32'h0);
    reg_read(REG_STATUS, rd_val);
    chk("state_zq", 32'(rd_val[18:8]), 32'h20);
    zq_grant <= 1'b1;
    wait (ready === 1'b1);
    chk_ready_status();
    chk("zq_done", 32'(zq_applied), 32'h1);
    chk("cmds_cold", 32'(cmd_count), 32'h0000_000A);
    chk("zq_req_off", 32'(zq_req), 32'h0);
    chk("mr11_odt", 32'(mr11), 32'(ODT_SETTING_DEF));
    chk("cbt_exit", 32'(mr13), 32'h0);
    chk("wl_exit", 32'(mr2), 32'h0);
    chk("mr1_kept", 32'(mr1), 32'h0);
    chk("std_hiz_cke", 32'(s_hiz), 32'h1);
    reg_write(REG_MRW, {18'h0, MR_ADDR_3, 8'hC0});
    for (n = 0; n < 40 && mr3 !== 8'hC0; n++) @(posedge mclk);
    chk("mr3_wr", 32'(mr3), 32'h0000_00C0);
    chk("last_cmd", 32'(last_cmd), 32'(CMD_MRW));
    repeat (2) @(posedge mclk);
    chk("cmds_mrw", 32'(cmd_count), 32'h0000_000B);
    reg_write(REG_CTRL, 32'h2);
    reg_read(REG_STATUS, rd_val);
    chk("state_rst", 32'(rd_val[18:8]), 32'h2);
    for (n = 0; n < 20 && in_reset !== 1'b1; n++) @(posedge mclk);
    chk("in_reset", 32'(in_reset), 32'h1);
    for (n = 0; n < 20 && mr3 !== 8'h00; n++) @(posedge mclk);
    chk("mr3_dflt", 32'(mr3), 32'h0);
    chk("hiz_rst", 32'(out_hiz), 32'h1);
    wait (ready === 1'b1);
    chk_ready_status();
    chk("zq_again", 32'(zq_applied), 32'h1);
    chk("cmds_warm", 32'(cmd_count), 32'h0000_0015);
    print_verdict();
  end
endmodule // dram_power_up_init_sequence_test
